//--- rtl/sdp_pkg.sv
`default_nettype none
package sdp_pkg;
    localparam int unsigned WORD_W      = 20;
    localparam int unsigned MB_W        = 5;
    localparam int unsigned SB_PER_WORD = 20;
    localparam int unsigned MB_PER_WORD = 4;
    localparam int unsigned ID_W        = 3;
    localparam int unsigned SLOT_W      = 5;
    localparam int unsigned MOD_N       = 4;
    localparam logic [4:0]  SLOT_RST    = 5'h00;
    localparam logic [19:0] WORD_RST    = 20'h00000;
    localparam logic [2:0]  ID_RST      = 3'h0;
    localparam logic [3:0]  OFF_RST     = 4'hf;

    typedef enum logic [1:0] {
        SDP_SLOW_ONE_BIT,
        SDP_FAST_ONE_BIT,
        SDP_SLOW_MULTI_BIT,
        SDP_FAST_MULTI_BIT
    } sdp_mod_e;
endpackage
`default_nettype wire

//--- rtl/sdp_sync2.sv
`default_nettype none
module sdp_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_q <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- rtl/sdp_packer.sv
`default_nettype none
module sdp_packer (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_ce,
    input  wire logic [1:0]  i_band_sel,
    input  wire logic [3:0]  i_mod_off,
    input  wire logic        i_conv_valid,
    input  wire logic [3:0]  i_one_bit,
    input  wire logic [19:0] i_multi_bit,
    input  wire logic        i_chip_number_pin_0,
    input  wire logic        i_chip_number_pin_1,
    input  wire logic        i_chip_number_pin_2,
    output logic      [3:0]  o_mod_enable,
    output logic      [2:0]  o_chip_number,
    output logic      [19:0] o_code,
    output logic             o_data_ready
);
    sdp_pkg::sdp_mod_e   active_q;
    logic [3:0]          off_q;
    logic [4:0]          slot_q;
    logic [4:0]          slot_d;
    logic [19:0]         shift_q;
    logic [19:0]         shift_d;
    logic [4:0]          last_slot;
    logic                multi;
    logic [4:0]          sample;
    logic                take;
    logic                word_done;
    logic [2:0]          chip_pins;
    logic                band_change;

    // Chip number pins are static but asynchronous to the clock
    sdp_sync2 #(.W(sdp_pkg::ID_W)) u_id_sync (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_ce    (i_ce),
        .i_async ({i_chip_number_pin_2, i_chip_number_pin_1, i_chip_number_pin_0}),
        .o_sync  (chip_pins)
    );

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_chip_number <= sdp_pkg::ID_RST;
        end else if (i_ce) begin
            o_chip_number <= chip_pins;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            active_q <= sdp_pkg::SDP_SLOW_ONE_BIT;
            off_q    <= sdp_pkg::OFF_RST;
        end else if (i_ce) begin
            active_q <= sdp_pkg::sdp_mod_e'(i_band_sel);
            off_q    <= i_mod_off;
        end
    end

    // One-hot enable: only the selected modulator, and only if not switched off
    for (genvar m = 0; m < sdp_pkg::MOD_N; m++) begin : g_mod_en
        assign o_mod_enable[m] = (active_q == sdp_pkg::sdp_mod_e'(m)) && !off_q[m];
    end

    assign band_change = active_q != sdp_pkg::sdp_mod_e'(i_band_sel);
    assign multi = (active_q == sdp_pkg::SDP_SLOW_MULTI_BIT) ||
                   (active_q == sdp_pkg::SDP_FAST_MULTI_BIT);
    assign last_slot = multi ? 5'(sdp_pkg::MB_PER_WORD - 1)
                             : 5'(sdp_pkg::SB_PER_WORD - 1);
    assign take = i_conv_valid && o_mod_enable[active_q] && !band_change;
    assign word_done = take && (slot_q == last_slot);

    always_comb begin
        sample = 5'h00;
        unique case (active_q)
            sdp_pkg::SDP_SLOW_ONE_BIT:   sample = {4'h0, i_one_bit[0]};
            sdp_pkg::SDP_FAST_ONE_BIT:   sample = {4'h0, i_one_bit[1]};
            sdp_pkg::SDP_SLOW_MULTI_BIT: sample = i_multi_bit[4:0];
            sdp_pkg::SDP_FAST_MULTI_BIT: sample = i_multi_bit[9:5];
        endcase
    end

    // Shift left so the oldest conversion ends up in the top bits
    always_comb begin
        shift_d = shift_q;
        slot_d  = slot_q;
        if (band_change) begin
            slot_d = sdp_pkg::SLOT_RST;
        end else if (take) begin
            if (multi) begin
                shift_d = {shift_q[14:0], sample};
            end else begin
                shift_d = {shift_q[18:0], sample[0]};
            end
            slot_d = word_done ? sdp_pkg::SLOT_RST : 5'(slot_q + 5'h01);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            slot_q  <= sdp_pkg::SLOT_RST;
            shift_q <= sdp_pkg::WORD_RST;
        end else if (i_ce) begin
            slot_q  <= slot_d;
            shift_q <= shift_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_code       <= sdp_pkg::WORD_RST;
            o_data_ready <= 1'b0;
        end else if (i_ce) begin
            o_data_ready <= word_done;
            if (word_done) begin
                o_code <= shift_d;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/sdp_sink.sv
`default_nettype none
module sdp_sink (
    input  wire logic        i_clk,
    input  wire logic        i_ready,
    input  wire logic [19:0] i_code,
    output logic             o_got,
    output logic      [19:0] o_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // Takes each word off the bus for the testbench to check against its queue
    always_ff @(posedge i_clk) begin
        o_got <= i_ready;
        if (i_ready) begin
            o_word <= i_code;
        end
    end
endmodule
`default_nettype wire

//--- tb/sdp_packer_monitor.sv
`default_nettype none
module sdp_packer_monitor (
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire logic [1:0]  i_band_sel,
    input wire logic [3:0]  i_mod_off,
    input wire logic        i_conv_valid,
    input wire logic        i_chip_number_pin_0,
    input wire logic        i_chip_number_pin_1,
    input wire logic        i_chip_number_pin_2,
    input wire logic [3:0]  o_mod_enable,
    input wire logic [2:0]  o_chip_number,
    input wire logic [19:0] o_code,
    input wire logic        o_data_ready
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    one_active_a: assert property ($onehot0(o_mod_enable)) else $error("two enabled");
    band_choice_a: assert property (
        o_mod_enable != 0 |-> o_mod_enable == 4'h1 << $past(i_band_sel)) else $error("band");
    off_mask_a: assert property (
        !$past(i_srst) |-> (o_mod_enable & $past(i_mod_off)) == 0) else $error("off");
    reset_clear_a: assert property (disable iff (1'b0)
        i_srst |=> o_code == 0 && !o_data_ready && o_mod_enable == 0) else $error("reset");
    chip_number_a: assert property (!i_srst [*4] |-> o_chip_number == $past(
        {i_chip_number_pin_2, i_chip_number_pin_1, i_chip_number_pin_0}, 3)) else $error("id");
    code_hold_a: assert property (
        !$past(i_srst) && !o_data_ready |-> $stable(o_code)) else $error("code moved");
    ready_cause_a: assert property (
        o_data_ready |-> $past(i_conv_valid)) else $error("ready without conversion");
    word_gap_a: assert property (
        o_data_ready |=> !o_data_ready [*3]) else $error("words too close");
endmodule
bind sdp_packer sdp_packer_monitor u_mon (.*);
`default_nettype wire

//--- tb/sdp_packer_tb.sv
`default_nettype none
module sdp_packer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_srst = 1, i_ce = 1, i_conv_valid = 0, o_data_ready, got;
    logic i_chip_number_pin_0 = 0, i_chip_number_pin_1 = 0, i_chip_number_pin_2 = 0;
    logic [1:0] i_band_sel = 0;
    logic [3:0] i_mod_off = 4'hf, i_one_bit = 0, o_mod_enable;
    logic [2:0] o_chip_number;
    logic [19:0] i_multi_bit = 0, o_code, word, exp, q[$];
    logic [31:0] lf = 32'hd5fd;
    int err_count = 0, check_count = 0, cyc = 0;
    sdp_packer uut (.*);
    sdp_sink sink (.i_clk(i_clk), .i_ready(o_data_ready), .i_code(o_code), .o_got(got),
        .o_word(word));
    always #12.5 i_clk = ~i_clk;
    function automatic logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(logic [19:0] s, e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Drives n conversions back to back; notes the packed word when p is set
    task automatic conv(int n, w, bit p);
        exp = 0;
        repeat (n) begin
            @(negedge i_clk);
            lf = nx(lf);
            i_conv_valid = 1;
            {i_one_bit, i_multi_bit} = lf[23:0];
            exp = w == 1 ? {exp[18:0], i_one_bit[i_band_sel]}
                : {exp[14:0], i_band_sel[0] ? i_multi_bit[9:5] : i_multi_bit[4:0]};
        end
        if (p) q.push_back(exp);
        @(negedge i_clk);
        i_conv_valid = 0;
    endtask
    initial begin
        repeat (12) @(negedge i_clk);
        i_srst = 0;
        for (int b = 0; b < 4; b++) begin
            i_band_sel = 2'(b);
            i_mod_off = 0;
            {i_chip_number_pin_2, i_chip_number_pin_1, i_chip_number_pin_0} = lf[2:0];
            repeat (4) @(negedge i_clk);
            chk(20'(o_mod_enable), 20'(4'h1 << b));
            chk(20'(o_chip_number), 20'(lf[2:0]));
            repeat (2) conv(b < 2 ? 20 : 4, b < 2 ? 1 : 5, 1);
            i_mod_off = 4'h1 << b;
            repeat (2) @(negedge i_clk);
            chk(20'(o_mod_enable), 0);
            conv(20, 1, 0);
        end
        i_mod_off = 0;
        i_band_sel = 0;
        repeat (2) @(negedge i_clk);
        // Partial word in the reset band, so only reset can clear the slot
        conv(3, 1, 0);
        i_srst = 1;
        @(negedge i_clk);
        i_srst = 0;
        repeat (2) @(negedge i_clk);
        conv(20, 1, 1);
        repeat (4) @(negedge i_clk);
        chk(20'(q.size()), 0);
        tally_and_finish;
    end
    always @(negedge i_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            tally_and_finish;
        end
        if (got) chk(word, q.size() ? q.pop_front() : ~word);
    end
endmodule
`default_nettype wire
